// ### design/cmtm_consts.svh
`ifndef CMTM_CONSTS_SVH
`define CMTM_CONSTS_SVH

// Register word offsets on the Avalon-MM slave
`define CMTM_OFS_CTRL      4'h0
`define CMTM_OFS_MATCH_A   4'h1
`define CMTM_OFS_MATCH_B   4'h2
`define CMTM_OFS_CMD       4'h3
`define CMTM_OFS_STATUS    4'h4
`define CMTM_OFS_ERT_A     4'h5
`define CMTM_OFS_ERT_B     4'h6
`define CMTM_OFS_CAPT_A    4'h7
`define CMTM_OFS_CAPT_B    4'h8

// Control register fields
`define CMTM_CTRL_MODE_LSB 0
`define CMTM_CTRL_EDGA_LSB 2
`define CMTM_CTRL_EDGB_LSB 4
`define CMTM_CTRL_TBA_BIT  6
`define CMTM_CTRL_TBB_BIT  7
`define CMTM_CTRL_GEA_BIT  8
`define CMTM_CTRL_GEB_BIT  9

// Command register bits (write one to act)
`define CMTM_CMD_CLR_HA    0
`define CMTM_CMD_CLR_HB    1
`define CMTM_CMD_CLR_EA    2
`define CMTM_CMD_CLR_EB    3
`define CMTM_CMD_START     4
`define CMTM_CMD_END       5
`define CMTM_CMD_RESELECT  6
`define CMTM_CMD_DIS_A     7
`define CMTM_CMD_DIS_B     8

// Edge select encodings
`define CMTM_EDGE_NONE     2'h0
`define CMTM_EDGE_RISE     2'h1
`define CMTM_EDGE_FALL     2'h2
`define CMTM_EDGE_ANY      2'h3

// Unmapped read value
`define CMTM_UNMAPPED_RD   32'h0

`endif

// ### design/cmtm_pkg.sv
package cmtm_pkg;

  typedef enum logic [1:0] {
    CMTM_SINGLE_COMPARE_TWO_EDGE_MODE          = 2'h0,
    CMTM_DUAL_COMPARE_ONE_EDGE_MODE            = 2'h1,
    CMTM_DUAL_COMPARE_TWO_EDGE_MODE            = 2'h2,
    CMTM_ANY_COMPARE_NONBLOCKING_ONE_EDGE_MODE = 2'h3
  } cmtm_mode_e;

  typedef enum logic [1:0] {
    CMTM_BUS_IDLE = 2'b01,
    CMTM_BUS_DONE = 2'b10
  } cmtm_bus_e;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } cmtm_avm_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } cmtm_avm_rsp_s;

  typedef struct packed {
    logic compare_hit_latch_a;
    logic compare_hit_latch_b;
    logic edge_latch_unit_a;
    logic edge_latch_unit_b;
  } cmtm_latch_s;

endpackage : cmtm_pkg

// ### design/cmtm_channel.sv
`timescale 1ns/1ps
`include "cmtm_consts.svh"

// What this block does
// - Request on first or second edge by mode
// - Unrequesting edge latch still sets, decodes
// - Unit B edge armed after unit A edge
// - Single-compare two-edge: hit A requests too
// - Early hit captures each unit's time base
// - Thread start copies captures, samples latches
// - Edge A before hit keeps edge capture
// - Hit blocked once both edges seen
// - Later edges untouched until reselect refresh
// - Uncaptured edge latch requests after thread
// - Dual-compare one-edge: second hit requests
// - Edge blocks all later hits
// - Edge captures both units' time bases
// - Dual two-edge: first events silent, edge A
// - Edge capture never overwritten by hit
// - Second edge sets B, requests, blocks
// - Both hits first: second hit requests
// - Any-compare mode: first hit also requests
// - Second hit before edge also requests
// - Uncleared other hit requests after thread
// - Blocked >= hit refires after edge cleared
// - Hits off until compare register written
module cmtm_channel #(
  parameter int TB_W = 24
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  // Avalon-MM slave
  input  wire cmtm_pkg::cmtm_avm_req_s avm_req,
  output cmtm_pkg::cmtm_avm_rsp_s      avm_rsp,
  // Pin and time bases
  input  wire logic                   pin_in,
  input  wire logic [TB_W-1:0]        time_base_counter_1,
  input  wire logic [TB_W-1:0]        time_base_counter_2,
  // Scheduler side
  output logic                        service_request,
  output logic                        vector_compare_a_or_edge_b,
  output logic                        vector_compare_b_or_edge_a,
  output cmtm_pkg::cmtm_latch_s       latch_view
);
  import cmtm_pkg::*;

  typedef struct packed {
    cmtm_bus_e             bus;
    logic [31:0]           rdata;
    logic [9:0]            ctrl;
    logic [TB_W-1:0]       match_a;
    logic [TB_W-1:0]       match_b;
    logic                  en_a;
    logic                  en_b;
    cmtm_latch_s           lat;
    cmtm_latch_s           snap;
    logic [TB_W-1:0]       capt_a;
    logic [TB_W-1:0]       capt_b;
    logic [TB_W-1:0]       ert_a;
    logic [TB_W-1:0]       ert_b;
    logic                  in_thread;
    logic                  pin_d;
    logic                  sr;
    logic                  vab;
    logic                  vba;
  } cmtm_state_s;

  cmtm_state_s st_reg;
  cmtm_state_s st_next;

  cmtm_mode_e      mode;
  logic [1:0]      edge_sel_a;
  logic [1:0]      edge_sel_b;
  logic [TB_W-1:0] tb_a;
  logic [TB_W-1:0] tb_b;
  logic            cmp_a;
  logic            cmp_b;
  logic            edge_a;
  logic            edge_b;
  logic            hit_a;
  logic            hit_b;
  logic            rise;
  logic            fall;
  logic            two_edge;
  logic            acc;
  logic            wr;
  logic [31:0]     cmd;

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel == `CMTM_EDGE_RISE && r) || (sel == `CMTM_EDGE_FALL && f) ||
               (sel == `CMTM_EDGE_ANY && (r || f));
  endfunction : edge_hit

  always_comb begin
    st_next    = st_reg;
    mode       = cmtm_mode_e'(st_reg.ctrl[`CMTM_CTRL_MODE_LSB +: 2]);
    edge_sel_a = st_reg.ctrl[`CMTM_CTRL_EDGA_LSB +: 2];
    edge_sel_b = st_reg.ctrl[`CMTM_CTRL_EDGB_LSB +: 2];
    tb_a       = st_reg.ctrl[`CMTM_CTRL_TBA_BIT] ? time_base_counter_2 : time_base_counter_1;
    tb_b       = st_reg.ctrl[`CMTM_CTRL_TBB_BIT] ? time_base_counter_2 : time_base_counter_1;
    cmp_a      = st_reg.ctrl[`CMTM_CTRL_GEA_BIT] ? (tb_a >= st_reg.match_a) : (tb_a == st_reg.match_a);
    cmp_b      = st_reg.ctrl[`CMTM_CTRL_GEB_BIT] ? (tb_b >= st_reg.match_b) : (tb_b == st_reg.match_b);
    rise       = pin_in && !st_reg.pin_d;
    fall       = !pin_in && st_reg.pin_d;
    two_edge   = (mode == CMTM_SINGLE_COMPARE_TWO_EDGE_MODE) || (mode == CMTM_DUAL_COMPARE_TWO_EDGE_MODE);
    st_next.pin_d = pin_in;
    edge_a = !st_reg.lat.edge_latch_unit_a && edge_hit(edge_sel_a, rise, fall);
    edge_b = st_reg.lat.edge_latch_unit_a && !st_reg.lat.edge_latch_unit_b && edge_hit(edge_sel_b, rise, fall);
    hit_a = st_reg.en_a && !st_reg.lat.compare_hit_latch_a && cmp_a;
    hit_b = st_reg.en_b && !st_reg.lat.compare_hit_latch_b && cmp_b &&
            (mode != CMTM_SINGLE_COMPARE_TWO_EDGE_MODE);
    if (mode == CMTM_SINGLE_COMPARE_TWO_EDGE_MODE && st_reg.lat.edge_latch_unit_b)
      hit_a = 1'b0;
    // Cleared edge unblocks a >= hit
    if ((mode == CMTM_DUAL_COMPARE_ONE_EDGE_MODE || mode == CMTM_ANY_COMPARE_NONBLOCKING_ONE_EDGE_MODE) &&
        st_reg.lat.edge_latch_unit_a) begin
      hit_a = 1'b0;
      hit_b = 1'b0;
    end
    if (mode == CMTM_DUAL_COMPARE_TWO_EDGE_MODE && st_reg.lat.edge_latch_unit_b) begin
      hit_a = 1'b0;
      hit_b = 1'b0;
    end
    // Hit captures before edge; never over an edge capture
    if ((hit_a || hit_b) && !st_reg.lat.edge_latch_unit_a) begin
      if (mode == CMTM_SINGLE_COMPARE_TWO_EDGE_MODE) begin
        st_next.capt_a = tb_a;
        st_next.capt_b = tb_b;
      end else begin
        if (hit_a)
          st_next.capt_a = tb_a;
        if (hit_b)
          st_next.capt_b = tb_b;
      end
    end
    // Hit after edge A only loads B
    if ((hit_a || hit_b) && st_reg.lat.edge_latch_unit_a && !st_reg.lat.edge_latch_unit_b &&
        (mode == CMTM_SINGLE_COMPARE_TWO_EDGE_MODE || hit_b))
      st_next.capt_b = tb_b;
    // Edge A captures per mode; both two-edge modes only A
    if (edge_a) begin
      st_next.capt_a = tb_a;
      if (!two_edge)
        st_next.capt_b = tb_b;
    end
    if (edge_b)
      st_next.capt_b = tb_b;
    if (edge_a)
      st_next.lat.edge_latch_unit_a = 1'b1;
    if (edge_b)
      st_next.lat.edge_latch_unit_b = 1'b1;
    if (hit_a)
      st_next.lat.compare_hit_latch_a = 1'b1;
    if (hit_b)
      st_next.lat.compare_hit_latch_b = 1'b1;

    // Bus slave: one wait cycle, then answer
    acc = avm_req.read || avm_req.write;
    wr  = 1'b0;
    cmd = avm_req.writedata;
    case (st_reg.bus)
      CMTM_BUS_IDLE: begin
        if (acc) begin
          st_next.bus = CMTM_BUS_DONE;
          if (avm_req.address == `CMTM_OFS_CTRL)
            st_next.rdata = {22'h0, st_reg.ctrl};
          else if (avm_req.address == `CMTM_OFS_MATCH_A)
            st_next.rdata = 32'(st_reg.match_a);
          else if (avm_req.address == `CMTM_OFS_MATCH_B)
            st_next.rdata = 32'(st_reg.match_b);
          else if (avm_req.address == `CMTM_OFS_STATUS)
            st_next.rdata = {26'h0, st_reg.in_thread, st_reg.sr, st_reg.lat};
          else if (avm_req.address == `CMTM_OFS_ERT_A)
            st_next.rdata = 32'(st_reg.ert_a);
          else if (avm_req.address == `CMTM_OFS_ERT_B)
            st_next.rdata = 32'(st_reg.ert_b);
          else if (avm_req.address == `CMTM_OFS_CAPT_A)
            st_next.rdata = 32'(st_reg.capt_a);
          else if (avm_req.address == `CMTM_OFS_CAPT_B)
            st_next.rdata = 32'(st_reg.capt_b);
          else
            st_next.rdata = `CMTM_UNMAPPED_RD;
        end
      end
      CMTM_BUS_DONE: begin
        st_next.bus = CMTM_BUS_IDLE;
        wr = avm_req.write;
      end
      default: st_next.bus = CMTM_BUS_IDLE;
    endcase
    if (wr) begin
      if (avm_req.address == `CMTM_OFS_CTRL)
        st_next.ctrl = avm_req.writedata[9:0];
      else if (avm_req.address == `CMTM_OFS_MATCH_A) begin
        st_next.match_a    = avm_req.writedata[TB_W-1:0];
        st_next.en_a       = 1'b1;
      end else if (avm_req.address == `CMTM_OFS_MATCH_B) begin
        st_next.match_b    = avm_req.writedata[TB_W-1:0];
        st_next.en_b       = 1'b1;
      end else if (avm_req.address == `CMTM_OFS_CMD) begin
        // Clears lose to a same-cycle set
        if (cmd[`CMTM_CMD_CLR_HA] && !hit_a)
          st_next.lat.compare_hit_latch_a = 1'b0;
        if (cmd[`CMTM_CMD_CLR_HB] && !hit_b)
          st_next.lat.compare_hit_latch_b = 1'b0;
        if (cmd[`CMTM_CMD_CLR_EA] && !edge_a)
          st_next.lat.edge_latch_unit_a = 1'b0;
        if (cmd[`CMTM_CMD_CLR_EB] && !edge_b)
          st_next.lat.edge_latch_unit_b = 1'b0;
        if (cmd[`CMTM_CMD_DIS_A])
          st_next.en_a = 1'b0;
        if (cmd[`CMTM_CMD_DIS_B])
          st_next.en_b = 1'b0;
        if (cmd[`CMTM_CMD_START] && !st_reg.in_thread) begin
          st_next.in_thread = 1'b1;
          st_next.ert_a     = st_reg.capt_a;
          st_next.ert_b     = st_reg.capt_b;
          st_next.snap      = st_reg.lat;
        end
        if (cmd[`CMTM_CMD_RESELECT] && st_reg.in_thread) begin
          st_next.ert_a = st_reg.capt_a;
          st_next.ert_b = st_reg.capt_b;
          st_next.snap  = st_reg.lat;
        end
        if (cmd[`CMTM_CMD_END])
          st_next.in_thread = 1'b0;
      end
    end

    // Request on pending latches; held off during a thread
    // Edge request by mode; hit A alone in single-compare, either hit in any-compare, both hits otherwise
    st_next.sr = 1'b0;
    if (!st_reg.in_thread) begin
      if (two_edge ? st_reg.lat.edge_latch_unit_b : st_reg.lat.edge_latch_unit_a)
        st_next.sr = 1'b1;
      case (mode)
        CMTM_SINGLE_COMPARE_TWO_EDGE_MODE:
          if (st_reg.lat.compare_hit_latch_a)
            st_next.sr = 1'b1;
        CMTM_ANY_COMPARE_NONBLOCKING_ONE_EDGE_MODE:
          if (st_reg.lat.compare_hit_latch_a || st_reg.lat.compare_hit_latch_b)
            st_next.sr = 1'b1;
        default:
          if (st_reg.lat.compare_hit_latch_a && st_reg.lat.compare_hit_latch_b)
            st_next.sr = 1'b1;
      endcase
    end
    st_next.vab = st_next.sr && (st_reg.lat.compare_hit_latch_a || st_reg.lat.edge_latch_unit_b);
    st_next.vba = st_next.sr && (st_reg.lat.compare_hit_latch_b || st_reg.lat.edge_latch_unit_a);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg     <= '0;
      st_reg.bus <= CMTM_BUS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    avm_rsp.readdata    = st_reg.rdata;
    avm_rsp.waitrequest = st_reg.bus != CMTM_BUS_DONE;
  end
  assign service_request            = st_reg.sr;
  assign vector_compare_a_or_edge_b = st_reg.vab;
  assign vector_compare_b_or_edge_a = st_reg.vba;
  assign latch_view                 = st_reg.snap;

  a_edge_b_order: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(st_reg.lat.edge_latch_unit_b) |-> $past(st_reg.lat.edge_latch_unit_a))
    else $error("edge B latched before edge A");
  a_thread_copy: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(st_reg.in_thread) |-> st_reg.ert_a == $past(st_reg.capt_a) && st_reg.snap == $past(st_reg.lat))
    else $error("changeover copy wrong");
  a_no_req_thread: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.in_thread |=> !st_reg.sr)
    else $error("request during thread");
  a_edge_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.lat.edge_latch_unit_a && $stable(st_reg.lat.edge_latch_unit_a) && !edge_b
    && !(st_reg.lat.edge_latch_unit_b == 1'b0 && (hit_a || hit_b)) |=> $stable(st_reg.capt_a))
    else $error("edge capture overwritten");
  a_hit_block: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode == CMTM_DUAL_COMPARE_ONE_EDGE_MODE && st_reg.lat.edge_latch_unit_a |-> !hit_a && !hit_b)
    else $error("hit after edge");
  a_hit_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_reg.en_a |=> !$rose(st_reg.lat.compare_hit_latch_a))
    else $error("disabled hit latched");
  a_dual_req: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode == CMTM_DUAL_COMPARE_ONE_EDGE_MODE && !st_reg.in_thread && st_reg.lat.compare_hit_latch_a
    && !st_reg.lat.compare_hit_latch_b && !st_reg.lat.edge_latch_unit_a |=> !st_reg.sr)
    else $error("first hit requested");
  a_any_req: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode == CMTM_ANY_COMPARE_NONBLOCKING_ONE_EDGE_MODE && !st_reg.in_thread
    && st_reg.lat.compare_hit_latch_b |=> st_reg.sr)
    else $error("any hit not requested");
  a_edge_req_one: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_reg.in_thread && !two_edge && st_reg.lat.edge_latch_unit_a |=> st_reg.sr)
    else $error("first edge not requested");
  a_edge_req_two: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_reg.in_thread && two_edge && st_reg.lat.edge_latch_unit_b |=> st_reg.sr)
    else $error("second edge not requested");
  a_first_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode == CMTM_DUAL_COMPARE_TWO_EDGE_MODE && !st_reg.lat.edge_latch_unit_b
    && !(st_reg.lat.compare_hit_latch_a && st_reg.lat.compare_hit_latch_b) |=> !st_reg.sr)
    else $error("first event requested");
  a_single_hit_req: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode == CMTM_SINGLE_COMPARE_TWO_EDGE_MODE && !st_reg.in_thread
    && st_reg.lat.compare_hit_latch_a |=> st_reg.sr)
    else $error("hit A not requested");
  a_both_edge_block: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode == CMTM_SINGLE_COMPARE_TWO_EDGE_MODE && st_reg.lat.edge_latch_unit_b |-> !hit_a)
    else $error("hit after both edges");
  a_second_edge_block: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode == CMTM_DUAL_COMPARE_TWO_EDGE_MODE && st_reg.lat.edge_latch_unit_b |-> !hit_a && !hit_b)
    else $error("hit after second edge");
  a_hit_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode == CMTM_SINGLE_COMPARE_TWO_EDGE_MODE && hit_a && !st_reg.lat.edge_latch_unit_a
    |=> st_reg.capt_a == $past(tb_a) && st_reg.capt_b == $past(tb_b))
    else $error("hit capture wrong");
  a_edge_capture_both: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode == CMTM_DUAL_COMPARE_ONE_EDGE_MODE || mode == CMTM_ANY_COMPARE_NONBLOCKING_ONE_EDGE_MODE) && edge_a
    |=> st_reg.capt_a == $past(tb_a) && st_reg.capt_b == $past(tb_b))
    else $error("edge capture of both bases wrong");
  a_edge_b_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    edge_b |=> st_reg.lat.edge_latch_unit_b && st_reg.capt_b == $past(tb_b))
    else $error("edge B capture wrong");
  a_ert_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.in_thread |=> $stable(st_reg.ert_a) || st_reg.ert_a == $past(st_reg.capt_a))
    else $error("engine time changed in thread");
  a_ge_refire: assert property (@(posedge clk_sys) disable iff (!nrst)
    mode == CMTM_ANY_COMPARE_NONBLOCKING_ONE_EDGE_MODE && st_reg.ctrl[`CMTM_CTRL_GEA_BIT] && st_reg.en_a
    && !st_reg.lat.compare_hit_latch_a && !st_reg.lat.edge_latch_unit_a && tb_a >= st_reg.match_a
    |=> st_reg.lat.compare_hit_latch_a)
    else $error("unblocked hit did not refire");
endmodule : cmtm_channel

// ### test/cmtm_far_end.sv
`timescale 1ns/1ps
// Pin and two time bases as the far side sees them
module cmtm_far_end #(
  parameter int TB_W = 24
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  // Bench requests
  input  wire logic            tick,
  input  wire logic            pin_lvl,
  // Pin and time bases
  output logic                 pin_in,
  output logic [TB_W-1:0]      tb1,
  output logic [TB_W-1:0]      tb2
);
  // Bases move only on tick so captured values are predictable
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_in <= 1'b0;
      tb1    <= '0;
      tb2    <= '0;
    end else begin
      pin_in <= pin_lvl;
      if (tick) begin
        tb1 <= tb1 + 1'b1;
        tb2 <= tb2 + 3'h5;
      end
    end
  end
endmodule : cmtm_far_end

// ### test/channel_match_transition_modes_tb.sv
`timescale 1ns/1ps
module channel_match_transition_modes_tb;
  import cmtm_pkg::*;
  logic          clk_sys;
  logic          nrst;
  cmtm_avm_req_s req;
  cmtm_avm_rsp_s rsp;
  logic          pin_lvl, tick, pin_in, sr, vab, vba;
  logic [23:0]   tb1, tb2, c1, c2, ea;
  cmtm_latch_s   lv;
  logic [31:0]   rdv;
  int            bad_count, total_checks;

  cmtm_channel u_cmtm_channel (.clk_sys(clk_sys), .nrst(nrst), .avm_req(req), .avm_rsp(rsp),
    .pin_in(pin_in), .time_base_counter_1(tb1), .time_base_counter_2(tb2), .service_request(sr),
    .vector_compare_a_or_edge_b(vab), .vector_compare_b_or_edge_a(vba), .latch_view(lv));
  cmtm_far_end u_cmtm_far_end (.clk_sys(clk_sys), .nrst(nrst), .tick(tick), .pin_lvl(pin_lvl),
    .pin_in(pin_in), .tb1(tb1), .tb2(tb2));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Request stands until waitrequest is seen low at a rising edge;
  // one idle edge follows so the strobe is never reassigned at once
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    req.address   <= a;
    req.read      <= ~w;
    req.write     <= w;
    req.writedata <= d;
    n = 0;
    @(posedge clk_sys);
    while (rsp.waitrequest !== 1'b0 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    if (rsp.waitrequest !== 1'b0) begin
      bad_count++;
      $display("wrong value t=%0t bus hang", $time);
      wrap_up;
    end else begin
      rdv = rsp.readdata;
      req.read  <= 1'b0;
      req.write <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : bus

  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rd

  // Sync, latch and request take three edges; one spare
  task pin_to(input logic v);
    pin_lvl <= v;
    repeat (4) @(posedge clk_sys);
  endtask : pin_to

  task step;
    tick <= 1'b1;
    @(posedge clk_sys);
    tick <= 1'b0;
    c1 = c1 + 24'h1;
    c2 = c2 + 24'h5;
    @(posedge clk_sys);
  endtask : step

  task cfg(input logic [31:0] c);
    pin_to(1'b0);
    wr(4'h3, 32'h18f);
    wr(4'h0, c);
  endtask : cfg

  task t_reset;
    rd(4'h4, 32'h0);
    chk({31'h0, sr}, 32'h0);
    rd(4'hf, 32'h0);
    wr(4'hf, 32'h3);
    rd(4'h0, 32'h0);
  endtask : t_reset

  task t_two_edge;
    cfg(32'ha4);
    step;
    pin_to(1'b1);
    ea = c1;
    rd(4'h4, 32'h02);
    chk({31'h0, sr}, 32'h0);
    step;
    pin_to(1'b0);
    rd(4'h4, 32'h13);
    chk({30'h0, vab, vba}, 32'h3);
    wr(4'h3, 32'h10);
    chk({28'h0, lv}, 32'h3);
    rd(4'h5, {8'h0, ea});
    rd(4'h6, {8'h0, c2});
    wr(4'h3, 32'h2c);
    // Hit A alone asks for service here and loads both captures
    wr(4'h1, {8'h0, c1});
    @(posedge clk_sys);
    rd(4'h4, 32'h18);
    wr(4'h3, 32'h10);
    rd(4'h5, {8'h0, c1});
    rd(4'h6, {8'h0, c2});
    wr(4'h3, 32'ha1);
  endtask : t_two_edge

  task t_ordered;
    cfg(32'h1a);
    // Edge B capture takes base 1; kept for the next scenario
    ea = c1;
    pin_to(1'b1);
    rd(4'h4, 32'h0);
    pin_to(1'b0);
    rd(4'h4, 32'h02);
    pin_to(1'b1);
    rd(4'h4, 32'h13);
  endtask : t_ordered

  task t_any_hit;
    cfg(32'h187);
    step;
    wr(4'h1, {8'h0, c1});
    // Request is one edge behind the latch
    @(posedge clk_sys);
    rd(4'h4, 32'h18);
    wr(4'h3, 32'h10);
    rd(4'h5, {8'h0, c1});
    rd(4'h6, {8'h0, ea});
    chk({28'h0, lv}, 32'h8);
    step;
    pin_to(1'b1);
    chk({28'h0, lv}, 32'h8);
    // Engine clears only the hit that brought it in; the edge blocks a re-hit
    wr(4'h3, 32'h21);
    @(posedge clk_sys);
    chk({31'h0, sr}, 32'h1);
    wr(4'h3, 32'h10);
    chk({28'h0, lv}, 32'h2);
    rd(4'h5, {8'h0, c1});
    rd(4'h6, {8'h0, c2});
    // Clearing the edge lets the >= compare fire again
    wr(4'h3, 32'h24);
    @(posedge clk_sys);
    rd(4'h4, 32'h18);
  endtask : t_any_hit

  task t_dual_hit;
    cfg(32'h1);
    wr(4'h1, {8'h0, c1});
    rd(4'h4, 32'h08);
    wr(4'h2, {8'h0, c1});
    @(posedge clk_sys);
    rd(4'h4, 32'h1c);
    chk({30'h0, vab, vba}, 32'h3);
  endtask : t_dual_hit

  initial begin
    nrst = 1'b0;
    req = '0;
    pin_lvl = 1'b0;
    tick = 1'b0;
    c1 = 24'h0;
    c2 = 24'h0;
    bad_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_two_edge;
    t_ordered;
    t_any_hit;
    t_dual_hit;
    wrap_up;
  end
endmodule : channel_match_transition_modes_tb
